/* logic/acr_pkg.sv */
// package for the converter configuration register block
// assumes a 25 MHz system clock and an spi mode 1 master outside
package acr_pkg;
	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int START_BIT         = 15;
	localparam int INPUT_SEL_HI      = 14;
	localparam int INPUT_SEL_LO      = 12;
	localparam int GAIN_HI           = 11;
	localparam int GAIN_LO           = 9;
	localparam int MODE_BIT          = 8;
	localparam int RATE_HI           = 7;
	localparam int RATE_LO           = 5;
	localparam int TEMP_BIT          = 4;
	localparam int PULL_BIT          = 3;
	localparam int VALID_HI          = 2;
	localparam int VALID_LO          = 1;
	localparam int RSVD_BIT          = 0;
	// ------------------------------------------------------------
	// reset values and codes
	// ------------------------------------------------------------
	localparam logic [2:0] INPUT_SEL_RST = 3'h0;
	localparam logic [2:0] GAIN_RST      = 3'h2;
	localparam logic       MODE_RST      = 1'h1;
	localparam logic [2:0] RATE_RST      = 3'h4;
	localparam logic       TEMP_RST      = 1'h0;
	localparam logic       PULL_RST      = 1'h1;
	localparam logic [1:0] WRITE_VALID_CODE = 2'h1;
	localparam logic       RSVD_READ     = 1'h1;
	// ------------------------------------------------------------
	// frame and timing
	// ------------------------------------------------------------
	localparam int WORD_BITS  = 16;
	localparam int FRAME_BITS = 32;
	// conversion length, deliberately small so a bench sees it end
	localparam int CONV_TIME_US = 4;
	localparam int CLK_MHZ      = 25;
	localparam int CONV_CYCLES  = CONV_TIME_US * CLK_MHZ;
	localparam logic [7:0] CONV_CYCLES_W = 8'(CONV_CYCLES);
endpackage

/* logic/acr_sync.sv */
// three stage synchroniser for one pin input
// assumes the pin is asynchronous to clk_sys
`timescale 1ns/1ps
module acr_sync
	import acr_pkg::*;
(
	// clock and reset
	input  wire logic clk_sys,
	input  wire logic rst,
	input  wire logic rst_val,
	// pin and result
	input  wire logic pin_in,
	output logic      level_out
);
	logic s1_r;
	logic s2_r;
	logic s3_r;

	always_ff @(posedge clk_sys)
	begin
		s1_r <= pin_in;
		s2_r <= s1_r;
		s3_r <= s2_r;
	end

	// a change counts only once stages two and three agree
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			level_out <= rst_val;
		else if (s2_r == s3_r)
			level_out <= s3_r;
	end
endmodule

/* logic/acr_config.sv */
// configuration register of a 16-bit sensor converter, spi mode 1 slave side
// assumes sclk idles low, cs_n frames each transfer, conversion core outside
//
// Notes on behaviour
// - start bit launches one conversion when idle in single-shot mode
// - start bit ignored while converting
// - start bit reads back zero
// - input select field bits 14:12, reset 000
// - gain field bits 11:9, reset 010
// - mode bit 8, one is single-shot
// - rate field bits 7:5, reset 100
// - temperature select bit 4, reset zero
// - pull enable drives weak pull when cs high
// - update only when bits 2:1 equal 01
// - reserved bit ignores writes, reads one
// - capture din on falling sclk edges
// - 32-bit frame returns written word in tail
// - continuous mode keeps converting back to back
`timescale 1ns/1ps
module acr_config
	import acr_pkg::*;
(
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst,
	// serial pins
	input  wire logic       sclk,
	input  wire logic       cs_n,
	input  wire logic       din,
	output logic            data_out_ready_n_o,
	output logic            data_out_ready_n_oe,
	output logic            data_out_pull_en,
	// conversion core
	input  wire logic [15:0] conv_result,
	output logic            conv_start,
	output logic            conv_busy,
	// configuration fields
	output logic [2:0]      input_pair_select,
	output logic [2:0]      gain_range_select,
	output logic            single_shot_mode,
	output logic [2:0]      sample_rate_select,
	output logic            temp_sensor_select
);
	// ------------------------------------------------------------
	// pin sampling
	// ------------------------------------------------------------
	logic sclk_s;
	logic cs_n_s;
	logic din_s;
	logic sclk_d_r;

	acr_sync u_sync_sclk (.clk_sys(clk_sys), .rst(rst), .rst_val(1'b0),
		.pin_in(sclk), .level_out(sclk_s));
	acr_sync u_sync_cs (.clk_sys(clk_sys), .rst(rst), .rst_val(1'b1),
		.pin_in(cs_n), .level_out(cs_n_s));
	acr_sync u_sync_din (.clk_sys(clk_sys), .rst(rst), .rst_val(1'b0),
		.pin_in(din), .level_out(din_s));

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			sclk_d_r <= 1'b0;
		else
			sclk_d_r <= sclk_s;
	end

	logic sclk_rise;
	logic sclk_fall;
	assign sclk_rise = sclk_s & ~sclk_d_r & ~cs_n_s;
	assign sclk_fall = ~sclk_s & sclk_d_r & ~cs_n_s;

	// ------------------------------------------------------------
	// shift engine
	// ------------------------------------------------------------
	logic [5:0]  bit_cnt_r;
	logic [15:0] rx_r;
	logic [15:0] tx_r;
	logic [15:0] echo_r;
	logic        word_done;
	logic [15:0] rx_nxt;

	assign rx_nxt    = {rx_r[14:0], din_s};
	assign word_done = sclk_fall && (bit_cnt_r == 6'(WORD_BITS - 1));

	always_ff @(posedge clk_sys)
	begin
		if (rst || cs_n_s)
			bit_cnt_r <= 6'h00;
		else if (sclk_fall && bit_cnt_r != 6'(FRAME_BITS))
			bit_cnt_r <= bit_cnt_r + 6'h01;
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			rx_r <= 16'h0000;
		else if (sclk_fall)
			rx_r <= rx_nxt;
	end

	// ------------------------------------------------------------
	// configuration register
	// ------------------------------------------------------------
	logic [2:0] in_sel_r;
	logic [2:0] gain_r;
	logic       mode_r;
	logic [2:0] rate_r;
	logic       temp_r;
	logic       pull_r;
	logic       write_ok;
	logic [15:0] readback;

	assign write_ok = word_done && rx_nxt[VALID_HI:VALID_LO] == WRITE_VALID_CODE;

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			in_sel_r <= INPUT_SEL_RST;
			gain_r   <= GAIN_RST;
			mode_r   <= MODE_RST;
			rate_r   <= RATE_RST;
			temp_r   <= TEMP_RST;
			pull_r   <= PULL_RST;
		end
		else if (write_ok)
		begin
			in_sel_r <= rx_nxt[INPUT_SEL_HI:INPUT_SEL_LO];
			gain_r   <= rx_nxt[GAIN_HI:GAIN_LO];
			mode_r   <= rx_nxt[MODE_BIT];
			rate_r   <= rx_nxt[RATE_HI:RATE_LO];
			temp_r   <= rx_nxt[TEMP_BIT];
			pull_r   <= rx_nxt[PULL_BIT];
		end
	end

	// start bit is never stored, reserved bit never written
	assign readback = {1'b0, in_sel_r, gain_r, mode_r, rate_r, temp_r, pull_r,
		WRITE_VALID_CODE, RSVD_READ};

	// ------------------------------------------------------------
	// conversion control
	// ------------------------------------------------------------
	logic [7:0] conv_cnt_r;
	logic       conv_req;

	// start needs mode set in both the incoming word and mode_r, so a start bit sent with a mode change is not taken
	assign conv_req = (write_ok && rx_nxt[START_BIT] && rx_nxt[MODE_BIT]
		&& mode_r) || (!mode_r && !conv_busy);

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			conv_busy  <= 1'b0;
			conv_start <= 1'b0;
			conv_cnt_r <= 8'h00;
		end
		else
		begin
			conv_start <= 1'b0;
			if (conv_busy)
			begin
				// a start arriving now is dropped, not queued
				if (conv_cnt_r == CONV_CYCLES_W - 8'h01)
					conv_busy <= 1'b0;
				conv_cnt_r <= conv_cnt_r + 8'h01;
			end
			else if (conv_req)
			begin
				conv_busy  <= 1'b1;
				conv_start <= 1'b1;
				conv_cnt_r <= 8'h00;
			end
		end
	end

	// ------------------------------------------------------------
	// output shifter: result first, then echo of the written word
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			echo_r <= 16'h0000;
		else if (word_done)
			echo_r <= write_ok ? {1'b0, rx_nxt[14:3], WRITE_VALID_CODE, RSVD_READ}
				: readback;
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst || cs_n_s)
			tx_r <= conv_result;
		else if (sclk_rise && bit_cnt_r == 6'(WORD_BITS))
			tx_r <= echo_r;
		else if (sclk_rise && bit_cnt_r != 6'h00)
			tx_r <= {tx_r[14:0], 1'b0};
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			data_out_ready_n_o  <= 1'b1;
			data_out_ready_n_oe <= 1'b0;
			data_out_pull_en    <= 1'b0;
		end
		else
		begin
			data_out_ready_n_o  <= tx_r[15];
			data_out_ready_n_oe <= ~cs_n_s;
			data_out_pull_en    <= cs_n_s & pull_r;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			input_pair_select  <= INPUT_SEL_RST;
			gain_range_select  <= GAIN_RST;
			single_shot_mode   <= MODE_RST;
			sample_rate_select <= RATE_RST;
			temp_sensor_select <= TEMP_RST;
		end
		else
		begin
			input_pair_select  <= in_sel_r;
			gain_range_select  <= gain_r;
			single_shot_mode   <= mode_r;
			sample_rate_select <= rate_r;
			temp_sensor_select <= temp_r;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	chk_bad_code_holds: assert property (@(posedge clk_sys) disable iff (rst)
		word_done && rx_nxt[VALID_HI:VALID_LO] != WRITE_VALID_CODE |=> $stable(readback))
		else $error("register changed without valid code");
	chk_start_once: assert property (@(posedge clk_sys) disable iff (rst)
		conv_start |=> conv_busy && !conv_start)
		else $error("start pulse not followed by busy");
	chk_busy_no_restart: assert property (@(posedge clk_sys) disable iff (rst)
		conv_busy && $past(conv_busy) |-> !conv_start)
		else $error("restart while converting");
	chk_start_reads_zero: assert property (@(posedge clk_sys) disable iff (rst)
		readback[15] == 1'b0 && readback[0] == 1'b1)
		else $error("start or reserved readback wrong");
	chk_pull_cs_high: assert property (@(posedge clk_sys) disable iff (rst)
		data_out_pull_en |-> !data_out_ready_n_oe)
		else $error("pull while driving");
	chk_cont_restart: assert property (@(posedge clk_sys) disable iff (rst)
		!mode_r && $fell(conv_busy) |=> conv_start)
		else $error("continuous mode did not restart");
	chk_gain_update: assert property (@(posedge clk_sys) disable iff (rst)
		write_ok |=> gain_r == $past(rx_nxt[11:9]))
		else $error("gain not stored");
	chk_mode_update: assert property (@(posedge clk_sys) disable iff (rst)
		write_ok |=> mode_r == $past(rx_nxt[8]) ##1 single_shot_mode == mode_r)
		else $error("mode not stored");
	chk_conv_len: assert property (@(posedge clk_sys) disable iff (rst)
		conv_start |-> ##99 conv_busy ##1 !conv_busy)
		else $error("conversion length");
	cov_write: cover property (@(posedge clk_sys) disable iff (rst) write_ok);
	cov_single: cover property (@(posedge clk_sys) disable iff (rst) conv_start && mode_r);
	cov_echo: cover property (@(posedge clk_sys) disable iff (rst)
		sclk_rise && bit_cnt_r == 6'(WORD_BITS));
endmodule

/* bench/acr_master.sv */
// spi mode 1 master model that drives the serial pins of the config block
// assumes clk_sys at 40 ns, so one serial bit is eight clk_sys cycles (320 ns)
`timescale 1ns/1ps
module acr_master
(
	// clock
	input  wire logic clk_sys,
	// serial pins
	input  wire logic dout_line,
	output logic      sclk,
	output logic      cs_n,
	output logic      din
);
	initial
	begin
		sclk = 1'b0;
		cs_n = 1'b1;
		din  = 1'b0;
	end
	// ------------------------------------------------------------
	// one 32-bit frame, msb first
	// ------------------------------------------------------------
	task automatic frame(input logic [31:0] tx, output logic [31:0] rx);
		rx = '0;
		@(posedge clk_sys) cs_n <= 1'b0;
		repeat (4) @(posedge clk_sys);
		for (int i = 0; i < 32; i++)
		begin
			@(posedge clk_sys);
			sclk <= 1'b1;
			din  <= tx[31 - i]; // change only after rising sclk
			repeat (4) @(posedge clk_sys);
			sclk <= 1'b0;
			repeat (3) @(posedge clk_sys);
			// sample late in the low phase, well clear of the sync delay
			@(negedge clk_sys) rx[31 - i] = dout_line;
		end
		repeat (4) @(posedge clk_sys);
		cs_n <= 1'b1;
		din  <= ~din;
		repeat (12) @(posedge clk_sys);
	endtask
endmodule

/* bench/tb.sv */
// self-checking bench for the converter configuration register
// assumes acr_master owns the serial pins and the bench owns the result word
`timescale 1ns/1ps
module tb
	import acr_pkg::*;
;
	logic        clk_sys, rst, sclk, cs_n, din, dout_o, dout_oe, pull_en;
	logic        conv_start, conv_busy, single_shot_mode, temp_sensor_select;
	logic [15:0] conv_result, cfg_m;
	logic [2:0]  input_pair_select, gain_range_select, sample_rate_select;
	int          errors = 0, checks = 0, starts = 0, busy_cyc = 0;
	// released line: pull-up if enabled, else a changing value
	wire         dout_line = dout_oe ? dout_o : (pull_en ? 1'b1 : ~dout_o);

	acr_config i_acr_config (.clk_sys(clk_sys), .rst(rst), .sclk(sclk), .cs_n(cs_n),
		.din(din), .data_out_ready_n_o(dout_o), .data_out_ready_n_oe(dout_oe),
		.data_out_pull_en(pull_en), .conv_result(conv_result), .conv_start(conv_start),
		.conv_busy(conv_busy), .input_pair_select(input_pair_select),
		.gain_range_select(gain_range_select), .single_shot_mode(single_shot_mode),
		.sample_rate_select(sample_rate_select), .temp_sensor_select(temp_sensor_select));
	acr_master i_acr_master (.clk_sys(clk_sys), .dout_line(dout_line), .sclk(sclk),
		.cs_n(cs_n), .din(din));

	initial
	begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys)
	begin
		if (conv_start === 1'b1)
			starts <= starts + 1;
		if (conv_busy === 1'b1)
			busy_cyc <= busy_cyc + 1;
	end
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [15:0] exp_word(logic [15:0] c);
		return {1'b0, c[14:3], WRITE_VALID_CODE, RSVD_READ};
	endfunction
	task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
		checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic xfer(logic [31:0] tx);
		logic [31:0] rx;
		@(posedge clk_sys) conv_result <= 16'($urandom);
		i_acr_master.frame(tx, rx);
		if (tx[18:17] == WRITE_VALID_CODE)
			cfg_m = tx[31:16];
		check("result", rx[31:16], conv_result);
		check("echo", rx[15:0], exp_word(cfg_m));
		check("fields", 16'({input_pair_select, gain_range_select, single_shot_mode,
			sample_rate_select, temp_sensor_select}), 16'(cfg_m[14:4]));
		check("pull", {15'h0, pull_en}, {15'h0, cfg_m[3]});
	endtask
	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial
	begin
		logic [15:0] w;
		int          s0, b0;
		rst = 1'b1;
		conv_result = 16'h0;
		cfg_m = 16'h058B;
		void'($urandom(85679));
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (4) @(posedge clk_sys);
		xfer(32'h0);
		$display("test reset_readback done");
		for (int i = 0; i < 12; i++)
		begin
			w = 16'($urandom);
			w[15] = 1'b0;
			w[2:1] = 2'(i);
			xfer({w, w});
		end
		$display("test random_writes done");
		xfer({16'h0103, 16'h0});
		repeat (120) @(posedge clk_sys);
		s0 = starts;
		xfer({16'h0103, 16'h0103});
		check("idle_start", 16'(starts - s0), 16'h0000);
		s0 = starts;
		b0 = busy_cyc;
		xfer({16'h8103, 16'h0});
		check("one_start", 16'(starts - s0), 16'h0001);
		check("busy_len", 16'(busy_cyc - b0), 16'(CONV_CYCLES));
		$display("test single_shot done");
		xfer({16'h0003, 16'h0003});
		s0 = starts;
		repeat (500) @(posedge clk_sys);
		check("continuous", 16'(starts - s0 >= 3), 16'h0001);
		xfer({16'h0103, 16'h0});
		$display("test continuous done");
		tally_and_finish();
	end
	initial
	begin
		repeat (30000) @(posedge clk_sys);
		errors++;
		tally_and_finish();
	end
endmodule
